// *** portb_defines.vh ***
`ifndef PORTB_DEFINES_VH
`define PORTB_DEFINES_VH
// ----------------------------------------
// Port geometry
// ----------------------------------------
`define PB_WIDTH        6
`define PB_RESET_DATA   6'h00
`define PB_RESET_DIR    6'h00
`define PB_RESET_PULL   6'h00
`define PB_RESET_INEN   6'h3F
// ----------------------------------------
// Bit positions
// ----------------------------------------
`define PB_OD_BIT       0
`define PB_PDN_BIT      3
`define PB_IRQ0_BIT     5
`define PB_IRQ1_BIT     0
`define PB_T3_BIT       5
// Pins that may carry the second timer's PWM
`define PB_T2_MASK      6'h15
// Pins with a pull-up available (bit 0 has none)
`define PB_PU_MASK      6'h3E
// ----------------------------------------
// Edge select codes
// ----------------------------------------
`define EDGE_BOTH       2'h0
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`endif

// *** pin_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module pin_sync (
    input  wire       clk_in,
    input  wire       rstn_in,
    input  wire       pin_in,
    output reg        level_out
);
    reg s1;
    reg s2;
    reg s3;
    // Level follows only once stages two and three agree
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1        <= 1'b0;
            s2        <= 1'b0;
            s3        <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_out <= s3;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// *** port_b_pin_function_logic.v ***
// Behaviour
// - Bits 1,2,4,5: input or push-pull, pull-up
// - Bit 3: push-pull, pull-up or pull-down
// - Bit 0: input or open-drain only
// - Bit 0 has no pull-up
// - Input enable low kills input and wake
// - Bit 0 input enable gates input, wake
// - Bit 5 is alternate interrupt line zero
// - Bit 0 is interrupt line one
// - Bit 5 may carry third timer PWM
// - Bits 0,2,4 may carry second timer PWM
`timescale 1ns/1ps
`default_nettype none
`include "portb_defines.vh"
module port_b_pin_function_logic (
    input  wire       CLOCK_IN,
    input  wire       RSTN_IN,
    input  wire [5:0] DATA_IN,
    input  wire [5:0] DIR_IN,
    input  wire [5:0] PULLUP_EN_IN,
    input  wire       PULLDOWN_EN_IN,
    input  wire [5:0] INPUT_EN_IN,
    input  wire [5:0] T2_ROUTE_IN,
    input  wire       T3_ROUTE_IN,
    input  wire       TIMER_TWO_PWM_IN,
    input  wire       TIMER_THREE_PWM_IN,
    input  wire       IRQ0_ALT_SEL_IN,
    input  wire [1:0] IRQ0_EDGE_IN,
    input  wire [1:0] IRQ1_EDGE_IN,
    input  wire [5:0] PIN_IN,
    output reg  [5:0] PIN_OUT,
    output reg  [5:0] PIN_OE_OUT,
    output reg  [5:0] PULLUP_OUT,
    output reg        PULLDOWN_OUT,
    output reg  [5:0] READ_OUT,
    output reg        WAKE_OUT,
    output reg        EXT_IRQ_ZERO_ALT_OUT,
    output reg        EXT_IRQ_ONE_OUT
);
    wire [5:0] sync_level;
    reg  [5:0] gated_prev;
    reg  [5:0] drive;
    reg  [5:0] oe;
    reg  [5:0] gated;
    reg  [5:0] pwm_sel;
    reg        next_irq0;
    reg        next_irq1;
    reg        rise0;
    reg        fall0;
    reg        rise1;
    reg        fall1;
    integer    i;

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PB_WIDTH; g = g + 1) begin : g_sync
            pin_sync u_sync (
                .clk_in    (CLOCK_IN),
                .rstn_in   (RSTN_IN),
                .pin_in    (PIN_IN[g]),
                .level_out (sync_level[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Output path
    // ----------------------------------------
    always @* begin
        // PWM routes only where the pin has that alternate
        pwm_sel = T2_ROUTE_IN & `PB_T2_MASK;
        pwm_sel[`PB_T3_BIT] = T3_ROUTE_IN;
        for (i = 0; i < `PB_WIDTH; i = i + 1) begin
            drive[i] = DATA_IN[i];
            oe[i]    = DIR_IN[i];
            if (pwm_sel[i]) begin
                drive[i] = (i == `PB_T3_BIT && T3_ROUTE_IN) ?
                           TIMER_THREE_PWM_IN : TIMER_TWO_PWM_IN;
                oe[i]    = 1'b1;
            end
        end
        // Open drain: drive only low, release for high
        oe[`PB_OD_BIT]    = oe[`PB_OD_BIT] & ~drive[`PB_OD_BIT];
        drive[`PB_OD_BIT] = 1'b0;
        gated = sync_level & INPUT_EN_IN;
    end

    // ----------------------------------------
    // Edge detection for interrupts
    // ----------------------------------------
    // Disabled input reads 0, so its edges cannot fire
    always @* begin
        rise0 = gated[`PB_IRQ0_BIT] & ~gated_prev[`PB_IRQ0_BIT];
        fall0 = ~gated[`PB_IRQ0_BIT] & gated_prev[`PB_IRQ0_BIT];
        rise1 = gated[`PB_IRQ1_BIT] & ~gated_prev[`PB_IRQ1_BIT];
        fall1 = ~gated[`PB_IRQ1_BIT] & gated_prev[`PB_IRQ1_BIT];
        case (IRQ0_EDGE_IN)
            `EDGE_RISE: next_irq0 = rise0;
            `EDGE_FALL: next_irq0 = fall0;
            default:    next_irq0 = rise0 | fall0;
        endcase
        next_irq0 = next_irq0 & IRQ0_ALT_SEL_IN;
        case (IRQ1_EDGE_IN)
            `EDGE_RISE: next_irq1 = rise1;
            `EDGE_FALL: next_irq1 = fall1;
            default:    next_irq1 = rise1 | fall1;
        endcase
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            PIN_OUT              <= 6'h00;
            PIN_OE_OUT           <= 6'h00;
            PULLUP_OUT           <= 6'h00;
            PULLDOWN_OUT         <= 1'b0;
            READ_OUT             <= 6'h00;
            WAKE_OUT             <= 1'b0;
            EXT_IRQ_ZERO_ALT_OUT <= 1'b0;
            EXT_IRQ_ONE_OUT      <= 1'b0;
            gated_prev           <= 6'h00;
        end else begin
            PIN_OUT      <= drive;
            PIN_OE_OUT   <= oe;
            // Pull resistors only matter while the pin is an input
            PULLUP_OUT   <= PULLUP_EN_IN & ~oe & `PB_PU_MASK;
            PULLDOWN_OUT <= PULLDOWN_EN_IN & ~oe[`PB_PDN_BIT];
            READ_OUT     <= gated;
            gated_prev   <= gated;
            WAKE_OUT     <= |(gated ^ gated_prev);
            EXT_IRQ_ZERO_ALT_OUT <= next_irq0;
            EXT_IRQ_ONE_OUT      <= next_irq1;
        end
    end
endmodule // port_b_pin_function_logic
`default_nettype wire

// *** pb_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pb_chk (
    input wire logic       CLOCK_IN,
    input wire logic       RSTN_IN,
    input wire logic [5:0] DATA_IN,
    input wire logic [5:0] DIR_IN,
    input wire logic       PULLDOWN_EN_IN,
    input wire logic [5:0] INPUT_EN_IN,
    input wire logic [5:0] T2_ROUTE_IN,
    input wire logic       T3_ROUTE_IN,
    input wire logic       TIMER_TWO_PWM_IN,
    input wire logic       TIMER_THREE_PWM_IN,
    input wire logic [1:0] IRQ1_EDGE_IN,
    input wire logic [5:0] PIN_OUT,
    input wire logic [5:0] PIN_OE_OUT,
    input wire logic       PULLDOWN_OUT,
    input wire logic [5:0] READ_OUT,
    input wire logic       WAKE_OUT,
    input wire logic       EXT_IRQ_ONE_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);
    a_od_low: assert property (PIN_OE_OUT[0] |-> !PIN_OUT[0])
        else $error("bit 0 driven high");
    a_od_release: assert property (DIR_IN[0] && DATA_IN[0] &&
        !T2_ROUTE_IN[0] |=> !PIN_OE_OUT[0]) else $error("bit 0 held");
    a_push_pull: assert property (DIR_IN[1] |=> PIN_OE_OUT[1] &&
        PIN_OUT[1] == $past(DATA_IN[1])) else $error("bit 1 drive");
    a_pull_down: assert property (PULLDOWN_EN_IN && !DIR_IN[3]
        |=> PULLDOWN_OUT) else $error("no pull-down");
    a_t3_pwm: assert property (T3_ROUTE_IN |=> PIN_OE_OUT[5] &&
        PIN_OUT[5] == $past(TIMER_THREE_PWM_IN)) else $error("bit 5 pwm");
    a_t2_pwm: assert property (T2_ROUTE_IN[4] |=> PIN_OE_OUT[4] &&
        PIN_OUT[4] == $past(TIMER_TWO_PWM_IN)) else $error("bit 4 pwm");
    a_wake_gate: assert property ((INPUT_EN_IN == 6'h00) [*4]
        |=> !WAKE_OUT) else $error("wake while disabled");
    // Pulse lands on the same edge as the read value changes
    a_irq1_edge: assert property ($changed(READ_OUT[0]) |->
        EXT_IRQ_ONE_OUT == ($past(READ_OUT[0]) ?
        $past(IRQ1_EDGE_IN) != 2'h1 : $past(IRQ1_EDGE_IN) != 2'h2))
        else $error("line one edge");
endmodule // pb_chk
bind port_b_pin_function_logic pb_chk i_chk (.*);
`default_nettype wire

// *** pb_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module pb_board (
    input wire logic [5:0] drv_in,
    input wire logic [5:0] oe_in,
    input wire logic [5:0] pullup_in,
    input wire logic [5:0] ext_in,
    input wire logic [5:0] ext_en_in,
    output logic     [5:0] level_out
);
    // Unpulled float shows the inverse, never a stale level
    assign level_out = (oe_in & drv_in) | (~oe_in & ((ext_en_in & ext_in)
        | (~ext_en_in & (pullup_in | ~ext_in))));
endmodule // pb_board
`default_nettype wire

// *** port_b_pin_function_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_b_pin_function_logic_tb;
    logic CLOCK_IN = 0, RSTN_IN = 0, PULLDOWN_EN_IN, T3_ROUTE_IN;
    logic TIMER_TWO_PWM_IN, TIMER_THREE_PWM_IN, IRQ0_ALT_SEL_IN;
    logic [1:0] IRQ0_EDGE_IN, IRQ1_EDGE_IN;
    logic [5:0] DATA_IN, DIR_IN, PULLUP_EN_IN, INPUT_EN_IN, T2_ROUTE_IN;
    logic [5:0] PIN_IN, PIN_OUT, PIN_OE_OUT, PULLUP_OUT, READ_OUT, ext;
    logic PULLDOWN_OUT, WAKE_OUT, EXT_IRQ_ZERO_ALT_OUT, EXT_IRQ_ONE_OUT;
    int fail_count = 0, tests_run = 0, n1, n0, nw;
    always #5 CLOCK_IN = ~CLOCK_IN;
    port_b_pin_function_logic i_dut (.*);
    pb_board i_board (.drv_in(PIN_OUT), .oe_in(PIN_OE_OUT), .ext_in(ext),
        .pullup_in(PULLUP_OUT), .ext_en_in(6'h21), .level_out(PIN_IN));
    task automatic chk(string nm, logic [5:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic step(int n);
        repeat (n) @(negedge CLOCK_IN);
    endtask
    // Window covers the synchroniser delay with margin
    task automatic pulses;
        {n1, n0, nw} = '0;
        repeat (12) begin
            @(negedge CLOCK_IN);
            n1 += (EXT_IRQ_ONE_OUT === 1'b1);
            n0 += (EXT_IRQ_ZERO_ALT_OUT === 1'b1);
            nw += (WAKE_OUT === 1'b1);
        end
    endtask
    task automatic t_drive;
        DIR_IN = 6'h3F;
        DATA_IN = 6'h2A;
        step(2);
        chk("drive", 6'h2A, PIN_OUT);
        chk("enable", 6'h3F, PIN_OE_OUT);
        DATA_IN = 6'h3F;
        step(2);
        chk("od drive", 6'h3E, PIN_OUT);
        chk("od enable", 6'h3E, PIN_OE_OUT);
    endtask
    task automatic t_pull;
        DIR_IN = 6'h00;
        PULLUP_EN_IN = 6'h37;
        PULLDOWN_EN_IN = 1;
        step(2);
        chk("pullup", 6'h36, PULLUP_OUT);
        chk("pulldown", 6'h01, {5'h00, PULLDOWN_OUT});
    endtask
    task automatic t_pwm;
        DATA_IN = 6'h00;
        T2_ROUTE_IN = 6'h3F;
        T3_ROUTE_IN = 1;
        {TIMER_TWO_PWM_IN, TIMER_THREE_PWM_IN} = 2'h3;
        step(2);
        chk("pwm high", 6'h34, PIN_OUT);
        chk("pwm high oe", 6'h34, PIN_OE_OUT);
        {TIMER_TWO_PWM_IN, TIMER_THREE_PWM_IN} = 2'h0;
        step(2);
        chk("pwm low", 6'h00, PIN_OUT);
        chk("pwm low oe", 6'h35, PIN_OE_OUT);
        {T2_ROUTE_IN, T3_ROUTE_IN} = '0;
    endtask
    task automatic t_irq;
        step(10);
        ext = 6'h21;
        pulses;
        chk("read", 6'h3F, READ_OUT);
        chk("rise", 6'h11, {n1[1:0], n0[1:0], nw[1:0]});
        ext = 6'h00;
        pulses;
        chk("fall", 6'h05, {n1[1:0], n0[1:0], nw[1:0]});
        INPUT_EN_IN = 6'h00;
        step(8);
        ext = 6'h21;
        pulses;
        chk("gated", 6'h00, READ_OUT);
        chk("gated ev", 6'h00, {n1[1:0], n0[1:0], nw[1:0]});
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {DATA_IN, DIR_IN, PULLUP_EN_IN, T2_ROUTE_IN, ext} = '0;
        {PULLDOWN_EN_IN, T3_ROUTE_IN} = 2'h0;
        {TIMER_TWO_PWM_IN, TIMER_THREE_PWM_IN, IRQ0_ALT_SEL_IN} = 3'h1;
        {IRQ0_EDGE_IN, IRQ1_EDGE_IN, INPUT_EN_IN} = {2'h2, 2'h1, 6'h3F};
        step(4);
        RSTN_IN = 1;
        t_drive;
        t_pull;
        t_pwm;
        t_irq;
        conclude;
    end
    initial begin
        #20000;
        fail_count++;
        conclude;
    end
endmodule // port_b_pin_function_logic_tb
`default_nettype wire
